// ### common/itm_pkg.sv
// package: constants and types for the instruction timing model
package itm_pkg;

    // fetch sources
    typedef enum logic [1:0] {
        ITM_SRC_ROM,
        ITM_SRC_RAM,
        ITM_SRC_EXT
    } itm_src_t;

    // instruction classes
    typedef enum logic [3:0] {
        ITM_CLS_PLAIN,
        ITM_CLS_COND_BRANCH,
        ITM_CLS_FIXED_BRANCH,
        ITM_CLS_MUL,
        ITM_CLS_DIV,
        ITM_CLS_MOV_DISP16
    } itm_cls_t;

    // external access kinds, highest priority first in the arbiter
    typedef enum logic [1:0] {
        ITM_ACC_NONE,
        ITM_ACC_WRITE,
        ITM_ACC_FETCH,
        ITM_ACC_READ
    } itm_acc_t;

    // clock: 20 MHz core clock, one state is two oscillator periods
    localparam int ITM_CLK_MHZ = 20;
    localparam int ITM_OSC_PER_STATE = 2;
    localparam int ITM_STATE_DIV = ITM_OSC_PER_STATE;

    // minimum state counts from internal rom
    localparam logic [7:0] ITM_ST_PLAIN = 8'h02;
    localparam logic [7:0] ITM_ST_BRANCH = 8'h04;
    localparam logic [7:0] ITM_ST_BR_SHORT = 8'h02;
    localparam logic [7:0] ITM_ST_MUL = 8'h0A;
    localparam logic [7:0] ITM_ST_DIV = 8'h14;
    localparam logic [7:0] ITM_ST_MOV_DISP = 8'h04;
    localparam logic [7:0] ITM_ST_ROM_BASE = 8'h02;

    // internal ram penalties
    localparam logic [7:0] ITM_RAM_ADD_2B = 8'h04;
    localparam logic [7:0] ITM_RAM_ADD_4B = 8'h06;

    // external access cycle composition
    localparam logic [7:0] ITM_ACT_BASE_DEMUX = 8'h02;
    localparam logic [7:0] ITM_ACT_BASE_MUX = 8'h03;
    localparam logic [7:0] ITM_MCW_MAX = 8'h0F;
    localparam logic [7:0] ITM_TSW_MAX = 8'h01;

    // pipeline fill offset and pipeline penalty steps
    localparam logic [7:0] ITM_FILL_OFFSET = 8'h06;
    localparam logic [7:0] ITM_PIPE_HALF = 8'h01;
    localparam logic [7:0] ITM_PIPE_FULL = 8'h02;

    // reset values
    localparam logic [15:0] ITM_TOTAL_RST = 16'h0000;
    localparam logic [7:0] ITM_COUNT_RST = 8'h00;

    // system configuration fields relevant to timing
    typedef struct packed {
        logic [3:0] memory_cycle_wait_field;
        logic tristate_wait_field;
        logic bus_mux;
        logic bus_8bit;
    } itm_cfg_t;

    // one instruction handed to the model
    typedef struct packed {
        itm_src_t src;
        itm_cls_t cls;
        logic four_byte;
        logic short_case;
        logic cache_inject;
        logic [1:0] pipe_ext;
        logic [7:0] add_states;
        logic [3:0] add_acts;
    } itm_instr_t;

    // external access requests from the pipeline stages
    typedef struct packed {
        logic wr_req;
        logic fetch_req;
        logic rd_req;
    } itm_req_t;

endpackage

// ### hw/itm_bus_ctrl.sv
// external bus controller: arbitrates and times external access cycles
`timescale 1ns/10ps

module itm_bus_ctrl
    import itm_pkg::*;
(
    // clock, reset and state enable
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_state_en,
    // requests and cycle length
    input wire itm_req_t i_req,
    input wire logic [7:0] i_act_states,
    // status
    output logic o_busy,
    output itm_acc_t o_grant,
    output logic o_done
);

    logic [7:0] cnt_ff;
    logic busy_ff;
    itm_acc_t grant_ff;
    logic done_ff;
    itm_acc_t nxt_grant;

    assign o_busy = busy_ff;
    assign o_grant = grant_ff;
    assign o_done = done_ff;

    // write first, then fetch, then read
    always_comb begin
        nxt_grant = ITM_ACC_NONE;
        if (i_req.wr_req) begin
            nxt_grant = ITM_ACC_WRITE;
        end else if (i_req.fetch_req) begin
            nxt_grant = ITM_ACC_FETCH;
        end else if (i_req.rd_req) begin
            nxt_grant = ITM_ACC_READ;
        end
    end

    // runs concurrently with the core, counting states of each access
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= ITM_COUNT_RST;
            busy_ff <= 1'b0;
            grant_ff <= ITM_ACC_NONE;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (i_state_en) begin
                if (!busy_ff) begin
                    if (nxt_grant != ITM_ACC_NONE) begin
                        busy_ff <= 1'b1;
                        grant_ff <= nxt_grant;
                        cnt_ff <= i_act_states - 8'h01;
                    end
                end else if (cnt_ff == ITM_COUNT_RST) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    grant_ff <= ITM_ACC_NONE;
                end else begin
                    cnt_ff <= cnt_ff - 8'h01;
                end
            end
        end
    end

endmodule

// ### hw/itm_timing_model.sv
// instruction timing model: per-instruction and section state accounting
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module itm_timing_model
    import itm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // configuration
    input wire itm_cfg_t i_cfg,
    // instruction stream
    input wire logic i_instr_valid,
    input wire itm_instr_t i_instr,
    input wire logic i_section_start,
    // external access requests
    input wire itm_req_t i_ext_req,
    // results
    output logic [7:0] o_instr_states,
    output logic o_instr_valid,
    output logic [15:0] o_section_states,
    output logic [7:0] o_act_states,
    output logic o_state_tick,
    output logic o_bus_busy,
    output itm_acc_t o_bus_grant,
    output logic o_bus_done
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // length of one external access cycle in states
    function automatic logic [7:0] act_len(input itm_cfg_t cfg);
        logic [7:0] base;
        base = cfg.bus_mux ? ITM_ACT_BASE_MUX : ITM_ACT_BASE_DEMUX;
        act_len = base + (ITM_MCW_MAX - {4'h0, cfg.memory_cycle_wait_field})
            + (ITM_TSW_MAX - {7'h00, cfg.tristate_wait_field});
    endfunction

    // internal rom minimum by class
    function automatic logic [7:0] rom_min(input itm_instr_t ins);
        logic [7:0] r;
        r = ITM_ST_PLAIN;
        case (ins.cls)
            ITM_CLS_PLAIN: r = ITM_ST_PLAIN;
            ITM_CLS_COND_BRANCH: r = ins.short_case ? ITM_ST_BR_SHORT : ITM_ST_BRANCH;
            ITM_CLS_FIXED_BRANCH: r = ITM_ST_BRANCH;
            ITM_CLS_MUL: r = ITM_ST_MUL;
            ITM_CLS_DIV: r = ITM_ST_DIV;
            ITM_CLS_MOV_DISP16: r = ITM_ST_MOV_DISP;
            default: r = ITM_ST_PLAIN;
        endcase
        rom_min = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state tick: one enable pulse per state of two core-clock periods

    logic [1:0] div_ff;
    logic tick_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_ff <= 2'h0;
            tick_ff <= 1'b0;
        end else begin
            if (div_ff == 2'(ITM_STATE_DIV - 1)) begin
                div_ff <= 2'h0;
                tick_ff <= 1'b1;
            end else begin
                div_ff <= div_ff + 2'h1;
                tick_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-instruction time

    logic [7:0] act_w;
    logic [7:0] rom_w;
    logic [7:0] nxt_instr;
    logic [7:0] acts_w;
    logic [7:0] pipe_w;

    assign act_w = act_len(i_cfg);
    assign rom_w = rom_min(i_instr);

    always_comb begin
        acts_w = i_instr.four_byte ? 8'h02 : 8'h01;
        if (i_cfg.bus_8bit) begin
            acts_w = {acts_w[6:0], 1'b0};
        end
        // pipeline effect: 1 = half machine cycle, 2 = full machine cycle
        case (i_instr.pipe_ext)
            2'h1: pipe_w = ITM_PIPE_HALF;
            2'h2: pipe_w = ITM_PIPE_FULL;
            default: pipe_w = 8'h00;
        endcase
        nxt_instr = rom_w;
        if (i_instr.cache_inject) begin
            nxt_instr = rom_w;
        end else begin
            case (i_instr.src)
                ITM_SRC_ROM: nxt_instr = rom_w;
                ITM_SRC_RAM: nxt_instr = rom_w
                    + (i_instr.four_byte ? ITM_RAM_ADD_4B : ITM_RAM_ADD_2B);
                ITM_SRC_EXT: nxt_instr = 8'(acts_w * act_w) + (rom_w - ITM_ST_ROM_BASE);
                default: nxt_instr = rom_w;
            endcase
        end
        // operand extras in states and access cycles
        nxt_instr = nxt_instr + i_instr.add_states
            + 8'({4'h0, i_instr.add_acts} * act_w) + pipe_w;
    end

    logic [7:0] instr_ff;
    logic ivalid_ff;
    logic [7:0] act_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            instr_ff <= ITM_COUNT_RST;
            ivalid_ff <= 1'b0;
            act_ff <= ITM_COUNT_RST;
        end else begin
            ivalid_ff <= i_instr_valid;
            act_ff <= act_w;
            if (i_instr_valid) begin
                instr_ff <= nxt_instr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // section total

    logic [15:0] total_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            total_ff <= ITM_TOTAL_RST;
        end else if (i_section_start) begin
            total_ff <= {8'h00, ITM_FILL_OFFSET}
                + (i_instr_valid ? {8'h00, nxt_instr} : 16'h0000);
        end else if (i_instr_valid) begin
            total_ff <= total_ff + {8'h00, nxt_instr};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external bus controller

    logic bus_busy_w;
    itm_acc_t bus_grant_w;
    logic bus_done_w;

    itm_bus_ctrl u_bus (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_state_en(tick_ff),
        .i_req(i_ext_req),
        .i_act_states(act_w),
        .o_busy(bus_busy_w),
        .o_grant(bus_grant_w),
        .o_done(bus_done_w)
    );

    logic bbusy_ff;
    itm_acc_t bgrant_ff;
    logic bdone_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bbusy_ff <= 1'b0;
            bgrant_ff <= ITM_ACC_NONE;
            bdone_ff <= 1'b0;
        end else begin
            bbusy_ff <= bus_busy_w;
            bgrant_ff <= bus_grant_w;
            bdone_ff <= bus_done_w;
        end
    end

    assign o_instr_states = instr_ff;
    assign o_instr_valid = ivalid_ff;
    assign o_section_states = total_ff;
    assign o_act_states = act_ff;
    assign o_state_tick = tick_ff;
    assign o_bus_busy = bbusy_ff;
    assign o_bus_grant = bgrant_ff;
    assign o_bus_done = bdone_ff;

endmodule

// ### test/itm_timing_model_asserts.sv
// checker: concurrent properties on the timing model ports
`timescale 1ns/10ps

module itm_timing_model_asserts
    import itm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // stimulus side
    input wire itm_cfg_t i_cfg,
    input wire logic i_instr_valid,
    input wire itm_instr_t i_instr,
    input wire logic i_section_start,
    input wire itm_req_t i_ext_req,
    // results
    input wire logic [7:0] o_instr_states,
    input wire logic o_instr_valid,
    input wire logic [15:0] o_section_states,
    input wire logic [7:0] o_act_states,
    input wire logic o_state_tick,
    input wire logic o_bus_busy,
    input wire itm_acc_t o_bus_grant,
    input wire logic o_bus_done
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    AST_VALID_ONE: assert property (i_instr_valid |=> o_instr_valid)
        else $error("instruction answer missing");
    AST_VALID_PULSE: assert property (!i_instr_valid |=> !o_instr_valid)
        else $error("instruction answer without request");
    AST_ACT_LEN: assert property (i_rst_b |=> o_act_states ==
        ($past(i_cfg.bus_mux) ? 8'h03 : 8'h02) + 8'h0F - 8'($past(i_cfg.memory_cycle_wait_field))
        + 8'h01 - 8'($past(i_cfg.tristate_wait_field)))
        else $error("access cycle length wrong");
    AST_SEC_ACC: assert property (i_instr_valid && !i_section_start |=>
        o_section_states == $past(o_section_states) + 16'(o_instr_states))
        else $error("section total not accumulated");
    AST_SEC_START: assert property (i_section_start |=> o_section_states ==
        16'h0006 + ($past(i_instr_valid) ? 16'(o_instr_states) : 16'h0000))
        else $error("section total not restarted with fill offset");
    AST_DIV: assert property (i_instr_valid && i_instr.src == ITM_SRC_ROM
        && i_instr.cls == ITM_CLS_DIV && i_instr.add_acts == 4'h0 && i_instr.pipe_ext == 2'h0
        |=> o_instr_states == 8'h14 + $past(i_instr.add_states))
        else $error("divide time wrong");
    AST_TICK: assert property (o_state_tick |=> !o_state_tick ##1 o_state_tick)
        else $error("state tick not every second clock");
    AST_DONE_PULSE: assert property (o_bus_done |=> !o_bus_done)
        else $error("bus done longer than one cycle");
    AST_BUSY_GRANT: assert property (o_bus_busy == (o_bus_grant != ITM_ACC_NONE))
        else $error("grant and busy disagree");
    AST_BUSY_BOUND: assert property ($rose(o_bus_busy) |-> ##[1:80] o_bus_done)
        else $error("access did not finish in time");
endmodule

bind itm_timing_model itm_timing_model_asserts u_chk (.i_core_clk, .i_rst_b, .i_cfg,
    .i_instr_valid, .i_instr, .i_section_start, .i_ext_req, .o_instr_states, .o_instr_valid,
    .o_section_states, .o_act_states, .o_state_tick, .o_bus_busy, .o_bus_grant, .o_bus_done);

// ### test/itm_ext_mem_model.sv
// partner: pipeline stages holding external access requests until served
`timescale 1ns/10ps

module itm_ext_mem_model
    import itm_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // new requests and controller status
    input wire itm_req_t i_post,
    input wire itm_acc_t i_grant,
    // held requests
    output itm_req_t o_req
);
    // a request stays up until the controller shows it granted; dropping it at
    // done would come too late and let the same kind be granted twice
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req <= '0;
        end else begin
            o_req.wr_req <= i_post.wr_req | (o_req.wr_req & (i_grant != ITM_ACC_WRITE));
            o_req.fetch_req <= i_post.fetch_req | (o_req.fetch_req & (i_grant != ITM_ACC_FETCH));
            o_req.rd_req <= i_post.rd_req | (o_req.rd_req & (i_grant != ITM_ACC_READ));
        end
    end
endmodule

// ### test/tb_top.sv
// testbench: timing formulas, section totals and bus arbitration order
`timescale 1ns/10ps

module tb_top;
    import itm_pkg::*;

    logic i_core_clk, i_rst_b, i_instr_valid, i_section_start;
    itm_cfg_t i_cfg;
    itm_instr_t i_instr;
    itm_req_t ext_req, post;
    logic [7:0] o_instr_states, o_act_states;
    logic [15:0] o_section_states, total;
    logic o_instr_valid, o_state_tick, o_bus_busy, o_bus_done;
    itm_acc_t o_bus_grant, prev_g;
    itm_acc_t grants[$];
    int failures, n_tests, cycles;

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    itm_timing_model uut (.i_core_clk, .i_rst_b, .i_cfg, .i_instr_valid, .i_instr,
        .i_section_start, .i_ext_req(ext_req), .o_instr_states, .o_instr_valid, .o_section_states,
        .o_act_states, .o_state_tick, .o_bus_busy, .o_bus_grant, .o_bus_done);

    itm_ext_mem_model u_mem (.i_clk(i_core_clk), .i_rst_b, .i_post(post), .i_grant(o_bus_grant),
        .o_req(ext_req));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [7:0] exp_t(input itm_cfg_t c, input itm_instr_t s);
        logic [7:0] act, rom, t;
        act = (c.bus_mux ? 8'h03 : 8'h02) + 8'h0F - 8'(c.memory_cycle_wait_field)
            + 8'h01 - 8'(c.tristate_wait_field);
        case (s.cls)
            ITM_CLS_PLAIN: rom = 8'h02;
            ITM_CLS_COND_BRANCH: rom = s.short_case ? 8'h02 : 8'h04;
            ITM_CLS_MUL: rom = 8'h0A;
            ITM_CLS_DIV: rom = 8'h14;
            default: rom = 8'h04;
        endcase
        if (s.src == ITM_SRC_ROM || s.cache_inject) t = rom;
        else if (s.src == ITM_SRC_RAM) t = rom + (s.four_byte ? 8'h06 : 8'h04);
        else t = act * (8'h01 + 8'(s.four_byte)) * (c.bus_8bit ? 8'h02 : 8'h01) + rom - 8'h02;
        return t + s.add_states + 8'(s.add_acts) * act + 8'(s.pipe_ext);
    endfunction

    task automatic rnd_instr(output itm_instr_t s);
        s = itm_instr_t'(23'($urandom));
        s.src = itm_src_t'($urandom_range(0, 2));
        s.cls = itm_cls_t'($urandom_range(0, 5));
        s.pipe_ext = 2'($urandom_range(0, 2));
    endtask

    task automatic send(input itm_instr_t s, input logic start);
        i_instr_valid <= 1'b1;
        i_instr <= s;
        i_section_start <= start;
        @(posedge i_core_clk);
    endtask

    // grant log and run limit
    always @(posedge i_core_clk) begin
        prev_g <= o_bus_grant;
        if (o_bus_grant != prev_g && o_bus_grant != ITM_ACC_NONE) grants.push_back(o_bus_grant);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        itm_instr_t s;
        i_rst_b = 1'b0;
        i_cfg = '0;
        i_instr_valid = 1'b0;
        i_instr = '0;
        i_section_start = 1'b0;
        post = '0;
        cycles = 0;
        void'($urandom(24));
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        // every class, both branch cases, every source, then random mixes
        for (int k = 0; k < 120; k++) begin
            @(posedge i_core_clk);
            i_cfg <= itm_cfg_t'(7'($urandom));
            repeat (2) @(posedge i_core_clk);
            rnd_instr(s);
            if (k < 36) begin
                s.cls = itm_cls_t'(k % 6);
                s.short_case = 1'((k / 6) % 2);
                s.src = itm_src_t'(k / 12);
                s.cache_inject = 1'b0;
            end
            if (k < 12) {s.add_acts, s.pipe_ext} = 6'h00;
            send(s, 1'b0);
            i_instr_valid <= 1'b0;
            #1;
            chk("instr_valid", 16'h0001, 16'(o_instr_valid));
            chk("instr_states", 16'(exp_t(i_cfg, s)), 16'(o_instr_states));
        end
        // back-to-back section with start on the first instruction
        @(posedge i_core_clk);
        total = 16'h0006;
        for (int k = 0; k < 10; k++) begin
            rnd_instr(s);
            total += 16'(exp_t(i_cfg, s));
            send(s, k == 0);
        end
        i_instr_valid <= 1'b0;
        i_section_start <= 1'b0;
        #1;
        chk("section_states", total, o_section_states);
        // three stages ask at once
        @(posedge i_core_clk);
        grants.delete();
        post <= 3'b111;
        @(posedge i_core_clk);
        post <= '0;
        for (int w = 0; w < 400 && grants.size() < 3; w++) @(posedge i_core_clk);
        chk("grant_count", 16'h0003, 16'(grants.size()));
        for (int k = 0; k < grants.size(); k++) chk("grant", 16'(k + 1), 16'(grants[k]));
        test_done();
    end
endmodule
